// ---- tb/sfr_far_side.sv ----
// Model of the external shutdown circuit and the host restart pins.
// Assumes an open-drain fail line with a pull-up.
`timescale 1ns/100ps
module sfr_far_side (
  input wire clk_sys,
  input wire fail_oe,
  output reg enable_pin = 1'b1,
  output reg switching_enable_pin = 1'b1,
  output reg system_off = 1'b0
);
  // Shutdown circuit is the primary protection and cuts power on a low fail line
  // A host restart (either pin low) powers the system back up
  always @(posedge clk_sys) begin
    if (!enable_pin || !switching_enable_pin) system_off <= 1'b0;
    else if (fail_oe) system_off <= 1'b1;
  end
  // Host restart: drop one pin for three cycles, then raise both
  task toggle(input sel);
    @(posedge clk_sys);
    if (sel) switching_enable_pin <= 1'b0;
    else enable_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    enable_pin <= 1'b1;
    switching_enable_pin <= 1'b1;
  endtask
endmodule // sfr_far_side

// ---- tb/sfr_serious_fault_sva.sv ----
// Port checker of the serious-fault response block.
// Assumes it is bound to sfr_serious_fault and sees only its ports.
`timescale 1ns/100ps
module sfr_sva (
  input wire clk_sys,
  input wire reset,
  input wire step_up_mode,
  input wire high_side_short_detect,
  input wire low_bus_gnd_short_detect,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire [5:0] phase_drive_outputs,
  input wire system_fail_output_oe,
  input wire system_fail_output_out,
  input wire latched_off,
  input wire [7:0] latched_cause
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_fail_with_latch: assert property (system_fail_output_oe == latched_off)
    else $error("fail pin and latch differ");
  a_latch_no_drive: assert property (latched_off |-> phase_drive_outputs == 6'h00)
    else $error("drive while latched");
  a_fail_has_cause: assert property ($rose(system_fail_output_oe) |-> latched_cause != 8'h00)
    else $error("fail without cause");
  a_fail_data_low: assert property (system_fail_output_out == 1'b0)
    else $error("fail pin data not low");
  a_reserved_no_cause: assert property (latched_cause[3] == 1'b0)
    else $error("reserved cause set");
  a_dn_hs_cause: assert property ($rose(latched_cause[0]) |-> $past(high_side_short_detect & !step_up_mode))
    else $error("cause 0 without step-down high-side short");
  a_up_hs_cause: assert property ($rose(latched_cause[1]) |-> $past(high_side_short_detect & step_up_mode))
    else $error("cause 1 without step-up high-side short");
  a_dn_lowbus_cause: assert property ($rose(latched_cause[2]) |-> $past(low_bus_gnd_short_detect & !step_up_mode))
    else $error("cause 2 without low-bus short");
  a_unmapped_read_zero: assert property (reg_rd && reg_addr != 8'hbd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // sfr_sva
bind sfr_serious_fault sfr_sva u_sva (.*);

// ---- tb/testbench.sv ----
// Self-checking bench of the serious-fault block with its far-side model.
// Assumes reads answer one cycle after the strobe and a restart clears the cause record.
`timescale 1ns/100ps
module testbench;
  reg clk_sys, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wp = 1'b0, up = 1'b0, rd_d = 1'b0, off_d = 1'b0;
  reg [7:0] addr = 8'h00, wdata = 8'h00, r;
  reg [3:0] det = 4'h0;
  reg [1:0] stp = 2'b00;
  reg [5:0] req = 6'h00;
  wire [7:0] rdata, cause;
  wire [5:0] drv;
  wire oe, off, en, sen, sys_off;
  int n_mismatch = 0, total_checks = 0, seed = 50271, b, i;
  int bit_of[7] = '{0, 1, 2, 4, 5, 6, 7};
  int det_of[7] = '{0, 0, 2, 1, 1, 3, 3};
  reg [7:0] expq[$];
  sfr_serious_fault uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(addr), .reg_wr(reg_wr), .reg_wdata(wdata),
    .reg_rd(reg_rd), .write_protect(wp), .reg_rdata(rdata), .step_up_mode(up), .high_side_short_detect(det[0]),
    .low_side_short_detect(det[1]), .low_bus_gnd_short_detect(det[2]), .high_bus_gnd_short_detect(det[3]),
    .second_level_overcurrent_stop(1'b0), .negative_overcurrent_stop(1'b0), .low_voltage_bus_uv_stop(stp[0]),
    .low_voltage_bus_ov_stop(1'b0), .high_voltage_bus_uv_stop(stp[1]), .enable_pin(en), .switching_enable_pin(sen),
    .phase_drive_request(req), .phase_drive_outputs(drv), .system_fail_output_out(), .system_fail_output_oe(oe),
    .latched_off(off), .latched_cause(cause));
  sfr_far_side far (.clk_sys(clk_sys), .fail_oe(oe), .enable_pin(en), .switching_enable_pin(sen), .system_off(sys_off));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge clk_sys);
    addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Takes the oldest expectation when read data or a latch-off appears
  always @(negedge clk_sys) begin
    if (rd_d) chk("read data", rdata, expq.pop_front());
    if (off && !off_d) chk("cause", cause, expq.size() ? expq.pop_front() : 8'hff);
    rd_d = reg_rd;
    off_d = off;
  end
  // Register access, then each fault class with hard and deferred response
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'hbd, 8'h00);
    wr(8'hbd, 8'h5a);
    wp <= 1'b1;
    wr(8'hbd, 8'hff);
    wp <= 1'b0;
    wr(8'hbc, 8'hff);
    rd(8'hbd, 8'h5a);
    rd(8'hbc, 8'h00);
    $display("register test done");
    for (i = 0; i < 7; i++) begin
      b = bit_of[i];
      r = $random(seed);
      wr(8'hbd, r & ~(8'h01 << b));
      req <= $random(seed);
      up <= (b == 1 || b == 5 || b == 7);
      expq.push_back(8'h01 << b);
      det <= 4'h1 << det_of[i];
      @(posedge clk_sys);
      det <= 4'h0;
      repeat (2) @(posedge clk_sys);
      chk("system off", {7'h00, sys_off}, 8'h01);
      far.toggle(b[0]);
      repeat (6) @(posedge clk_sys);
      chk("latched", {7'h00, off}, 8'h00);
      wr(8'hbd, r | (8'h01 << b));
      det <= 4'h1 << det_of[i];
      repeat (3) @(posedge clk_sys);
      chk("drive", {2'b00, drv}, {2'b00, req});
      chk("fail released", {7'h00, oe}, 8'h00);
      stp <= (b == 1) ? 2'b10 : 2'b01;
      repeat (2) @(posedge clk_sys);
      chk("stopped drive", {2'b00, drv}, 8'h00);
      det <= 4'h0;
      stp <= 2'b00;
      rd(8'hbd, r | (8'h01 << b));
      $display("fault class %0d done", b);
    end
    repeat (3) @(posedge clk_sys);
    tally_and_finish;
  end
  // Cuts a hang short
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // testbench

// ---- verilog/sfr_fault_map.vh ----
// Constants of the serious-fault response block: command code, field positions, reset values.
// Included by the main design file of this block, not by the pin synchroniser; holds definitions only.
`ifndef SFR_FAULT_MAP_VH
`define SFR_FAULT_MAP_VH

// Command code of the response control register on the management bus
`define SFR_CTRL_ADDR 8'hbd
`define SFR_CTRL_RESET 8'h00
`define SFR_ZERO_BYTE 8'h00

// Response select bits: 0 = hard latch-off, 1 = defer to ordinary settings
`define SFR_BIT_DN_HS_SHORT 0
`define SFR_BIT_UP_HS_SHORT 1
`define SFR_BIT_DN_LOW_BUS_GND 2
`define SFR_BIT_RESERVED 3
`define SFR_BIT_DN_LS_SHORT 4
`define SFR_BIT_UP_LS_SHORT 5
`define SFR_BIT_DN_HIGH_BUS_GND 6
`define SFR_BIT_UP_HIGH_BUS_GND 7

// Width of the fault cause record (one bit per register bit, reserved bit reads 0)
`define SFR_CAUSE_W 8
`define SFR_PHASES 6
`define SFR_SYNC_W 2

// Idle level of one phase drive output, and reset value of the restart edge history
`define SFR_PHASE_IDLE 1'b0
`define SFR_PIN_HIST_RESET 2'h0

`endif

// ---- verilog/sfr_pin_sync.v ----
// Two-stage synchroniser for asynchronous pin inputs of the serious-fault block.
// Assumes the pins are quasi-static levels; one generate lane per pin.
`timescale 1ns/100ps

module sfr_pin_sync #(
  parameter WIDTH = 2
) (
  input wire clk_sys,
  input wire reset,
  input wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] pin_sync
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
      reg stage_a;
      reg stage_b;
      // First stage is read only by the second stage
      always @(posedge clk_sys) begin
        if (reset) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else begin
          stage_a <= pin_async[i];
          stage_b <= stage_a;
        end
      end
      assign pin_sync[i] = stage_b;
    end
  endgenerate

endmodule // sfr_pin_sync

// ---- verilog/sfr_serious_fault.v ----
// Serious-fault response logic: control register, fault steering, latch-off and fail pin drive.
// Assumes qualified detector levels and ordinary-fault stop requests come from logic on clk_sys,
// and that the enable and switching-enable pins are asynchronous.
`timescale 1ns/100ps
`include "sfr_fault_map.vh"

// Overview of operation
// - One-byte read/write response register, write-protectable, reset to zero.
// - Serious faults come from switch short and bus ground short detectors.
// - Hard-response fault stops all phase outputs and pulls fail output low.
// - Bit 0 clear: step-down high-side short pulls fail low, latches off.
// - Bit 0 set: fail released; stop follows overcurrent-2 and low-bus undervoltage.
// - Bit 1 clear: step-up high-side short pulls fail low, latches off.
// - Bit 1 set: stop follows overcurrent-2, high-bus UV, low-bus OV.
// - Bit 2 clear: step-down low-bus ground short pulls fail low, latches off.
// - Bit 2 set: stop follows negative overcurrent and low-bus undervoltage.
// - Bit 4: step-down low-side short; set defers to negative overcurrent, low-bus UV.
// - Bit 5: step-up low-side short; set defers to overcurrent-2, low-bus UV.
// - Bit 6: step-down high-bus ground short; set defers to ordinary settings.
// - Bit 7: step-up high-bus ground short; set defers to ordinary settings.
module sfr_serious_fault (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire write_protect,
  output reg [7:0] reg_rdata,
  input wire step_up_mode,
  input wire high_side_short_detect,
  input wire low_side_short_detect,
  input wire low_bus_gnd_short_detect,
  input wire high_bus_gnd_short_detect,
  input wire second_level_overcurrent_stop,
  input wire negative_overcurrent_stop,
  input wire low_voltage_bus_uv_stop,
  input wire low_voltage_bus_ov_stop,
  input wire high_voltage_bus_uv_stop,
  input wire enable_pin,
  input wire switching_enable_pin,
  input wire [5:0] phase_drive_request,
  output reg [5:0] phase_drive_outputs,
  output wire system_fail_output_out,
  output reg system_fail_output_oe,
  output reg latched_off,
  output reg [7:0] latched_cause
);

  reg [7:0] ctrl;
  reg [7:0] fault_hit;
  reg [7:0] hard_hit;
  reg [7:0] soft_stop;
  reg [1:0] pins_prev;
  wire [1:0] pins_sync;
  wire ctrl_write;
  wire restart_toggle;
  wire any_hard;
  wire deferred_stop;
  wire run_ok;
  reg [7:0] next_ctrl;
  reg [7:0] next_rdata;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] next_cause;
  genvar ph;

  // Latch-off states, one-hot
  localparam ST_RUN = 2'h1;
  localparam ST_LATCHED = 2'h2;

  // Enable and switching-enable pins cross into clk_sys
  sfr_pin_sync #(
    .WIDTH(`SFR_SYNC_W)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async({switching_enable_pin, enable_pin}),
    .pin_sync(pins_sync)
  );

  // Response register write, blocked while protected
  assign ctrl_write = reg_wr && (reg_addr == `SFR_CTRL_ADDR) && !write_protect;
  always @* begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl = reg_wdata;
    end
  end

  // Response register; all eight bits kept, the reserved one included
  always @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= `SFR_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Registered read data; other command codes read zero
  always @* begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = (reg_addr == `SFR_CTRL_ADDR) ? ctrl : `SFR_ZERO_BYTE;
    end
  end

  // Read data hold until the next read strobe
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= `SFR_ZERO_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Qualified detector levels steered by conversion direction into fault classes
  always @* begin
    fault_hit = `SFR_ZERO_BYTE;
    fault_hit[`SFR_BIT_DN_HS_SHORT] = high_side_short_detect && !step_up_mode;
    fault_hit[`SFR_BIT_UP_HS_SHORT] = high_side_short_detect && step_up_mode;
    fault_hit[`SFR_BIT_DN_LOW_BUS_GND] = low_bus_gnd_short_detect && !step_up_mode;
    fault_hit[`SFR_BIT_DN_LS_SHORT] = low_side_short_detect && !step_up_mode;
    fault_hit[`SFR_BIT_UP_LS_SHORT] = low_side_short_detect && step_up_mode;
    fault_hit[`SFR_BIT_DN_HIGH_BUS_GND] = high_bus_gnd_short_detect && !step_up_mode;
    fault_hit[`SFR_BIT_UP_HIGH_BUS_GND] = high_bus_gnd_short_detect && step_up_mode;
  end

  // Clear select bit means hard response; reserved bit never forms a class
  always @* begin
    hard_hit = fault_hit & ~ctrl;
    hard_hit[`SFR_BIT_RESERVED] = 1'b0;
  end

  // Deferred classes stop switching only when their ordinary responses ask it
  always @* begin
    soft_stop = `SFR_ZERO_BYTE;
    soft_stop[`SFR_BIT_DN_HS_SHORT] = second_level_overcurrent_stop || low_voltage_bus_uv_stop;
    soft_stop[`SFR_BIT_UP_HS_SHORT] = second_level_overcurrent_stop || high_voltage_bus_uv_stop
                                      || low_voltage_bus_ov_stop;
    soft_stop[`SFR_BIT_DN_LOW_BUS_GND] = negative_overcurrent_stop || low_voltage_bus_uv_stop;
    soft_stop[`SFR_BIT_DN_LS_SHORT] = negative_overcurrent_stop || low_voltage_bus_uv_stop;
    soft_stop[`SFR_BIT_UP_LS_SHORT] = second_level_overcurrent_stop || low_voltage_bus_uv_stop;
    soft_stop[`SFR_BIT_DN_HIGH_BUS_GND] = second_level_overcurrent_stop || low_voltage_bus_uv_stop;
    soft_stop[`SFR_BIT_UP_HIGH_BUS_GND] = second_level_overcurrent_stop || low_voltage_bus_uv_stop;
  end

  assign any_hard = |hard_hit;
  assign deferred_stop = |(fault_hit & ctrl & soft_stop);

  // A falling edge on either enable pin is the restart toggle
  assign restart_toggle = |(pins_prev & ~pins_sync);
  always @(posedge clk_sys) begin
    if (reset) begin
      pins_prev <= `SFR_PIN_HIST_RESET;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  // Latch-off state machine; a new hard fault wins over a restart toggle in the same cycle.
  // Causes keep accumulating while latched so the host sees every hard-response class that fired.
  always @* begin
    next_state = state;
    next_cause = latched_cause;
    case (state)
      ST_RUN: begin
        if (any_hard) begin
          next_state = ST_LATCHED;
          next_cause = latched_cause | hard_hit;
        end
      end
      ST_LATCHED: begin
        if (any_hard) begin
          next_cause = latched_cause | hard_hit;
        end else if (restart_toggle) begin
          next_state = ST_RUN;
          next_cause = `SFR_ZERO_BYTE;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_cause = `SFR_ZERO_BYTE;
      end
    endcase
  end

  // State and its visible copies; the fail pin is open drain, pulled low while latched.
  // Enable and latch flag load from the same next state, so they can never disagree.
  assign system_fail_output_out = 1'b0;
  always @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_RUN;
      latched_off <= 1'b0;
      latched_cause <= `SFR_ZERO_BYTE;
      system_fail_output_oe <= 1'b0;
    end else begin
      state <= next_state;
      latched_off <= (next_state == ST_LATCHED);
      latched_cause <= next_cause;
      system_fail_output_oe <= (next_state == ST_LATCHED);
    end
  end

  // Phase drive gated by both enables, latch-off and deferred stops
  assign run_ok = (&pins_sync) && !latched_off && !any_hard && !deferred_stop;

  // One gated flip-flop per phase; all phases stop together on any stop reason.
  // Drive resumes only once both synchronised enables are high again after a restart.
  generate
    for (ph = 0; ph < `SFR_PHASES; ph = ph + 1) begin : g_phase
      always @(posedge clk_sys) begin
        if (reset) begin
          phase_drive_outputs[ph] <= `SFR_PHASE_IDLE;
        end else begin
          phase_drive_outputs[ph] <= run_ok && phase_drive_request[ph];
        end
      end
    end
  endgenerate

endmodule // sfr_serious_fault
